// ---- logic/scl_regs.svh ----
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH

// Wishbone register byte offsets
`define SCL_REG_STRAPS 8'h00
`define SCL_REG_MODE 8'h04
`define SCL_REG_CTRL 8'h08
`define SCL_REG_STATUS 8'h0c

// Mode strap codes
`define SCL_MODE_RGMII_WAKE_IND 4'h8
`define SCL_MODE_RGMII_WAKE_IRQ 4'ha
`define SCL_MODE_RGMII_1000FD 4'hc
`define SCL_MODE_RGMII_NOWAKE 4'he
`define SCL_MODE_NAND_TREE 4'h4
`define SCL_MODE_POWER_DOWN 4'h7

// Address upper bits always zero
`define SCL_ADDR_UPPER 2'h0

// Control register fields
`define SCL_CTRL_BCAST_BIT 0
`define SCL_CTRL_RECOV_BIT 1

// Advertisement field: {1000FD,1000HD,10/100FD,10/100HD}
`define SCL_ADV_FULL 4'hb
`define SCL_ADV_1000FD_ONLY 4'h8
`define SCL_ADV_NONE 4'h0

`endif

// ---- logic/scl_pkg.sv ----
`default_nettype none
package scl_pkg;
    typedef enum logic [2:0] {
        SCL_OP_UNSUPPORTED,
        SCL_OP_RGMII_WAKE_IND,
        SCL_OP_RGMII_WAKE_IRQ,
        SCL_OP_RGMII_NOWAKE,
        SCL_OP_NAND_TREE,
        SCL_OP_POWER_DOWN
    } scl_op_e;

    typedef struct packed {
        logic [3:0] mode;
        logic [2:0] mgmtAddr;
        logic broadcastAddr;
        logic refclkOut;
        logic indicatorStyle;
    } scl_straps_s;

    typedef struct packed {
        scl_op_e op;
        logic [3:0] advert;
        logic wakeEventOnIndicatorPin;
        logic wakeEventOnIrqPin;
    } scl_mode_s;
endpackage
`default_nettype wire

// ---- logic/strap_config_latch.sv ----
// Operation
// - Sample all straps at reset pin release
// - Decode RGMII mode codes and advertisement
// - Code 0100 NAND tree, 0111 power down
// - Address is three strap bits, upper zero
// - Broadcast strap sets enable bit default
// - Broadcast strap inverted versus enable bit
// - Clock strap high enables reference clock output
// - Reference clock local default, recovered selectable
// - Indicator strap 1 individual, 0 tri-color
// - Address bits follow pull direction, 0..7
//
// Implementation choices: the Wishbone register port and the register addresses.
`default_nettype none
`include "scl_regs.svh"

module strap_config_latch
    import scl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic resetPinN,
    input wire scl_straps_s strapPins,
    input wire logic localRefClk,
    input wire logic recoveredRxClk,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output scl_mode_s modeCfg,
    output logic [4:0] mgmtAddr,
    output logic broadcastAddrEnableBit,
    output logic refclkOutPin,
    output logic refclkOutEnable,
    output logic indicatorStyle,
    output logic configValid
);

    ////////////////////////////////////////////////////////////////////////
    // Reset pin synchroniser and release detect

    logic [2:0] rstSync_r;
    logic [2:0] rstSync_nxt;
    logic rstStable_r;
    logic rstStable_nxt;
    logic release_w;

    always_comb begin
        rstSync_nxt = {rstSync_r[1:0], resetPinN};
        rstStable_nxt = rstStable_r;
        // Change counts once the second and third stages agree
        if (rstSync_r[1] == rstSync_r[2]) begin
            rstStable_nxt = rstSync_r[2];
        end
        release_w = rstStable_nxt & ~rstStable_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rstSync_r <= 3'h0;
            rstStable_r <= 1'b0;
        end else if (clkEn) begin
            rstSync_r <= rstSync_nxt;
            rstStable_r <= rstStable_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for straps and clock sources

    localparam int PIN_W = $bits(scl_straps_s) + 2;

    // Bit order: recovered clock, local clock, then the strap struct
    logic [PIN_W-1:0] pinRaw_w;
    logic [PIN_W-1:0] pinSync_w;
    scl_straps_s strapSync_w;
    logic localClkSync_w;
    logic recovClkSync_w;

    assign pinRaw_w = {recoveredRxClk, localRefClk, strapPins};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_pinSync
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic filt_r;
            logic filt_nxt;

            // A level counts only once two late stages agree
            always_comb begin
                filt_nxt = filt_r;
                if (s2_r == s3_r) begin
                    filt_nxt = s3_r;
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    filt_r <= 1'b0;
                end else if (clkEn) begin
                    s1_r <= pinRaw_w[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    filt_r <= filt_nxt;
                end
            end

            assign pinSync_w[gi] = filt_r;
        end
    endgenerate

    assign strapSync_w = pinSync_w[PIN_W-3:0];
    assign localClkSync_w = pinSync_w[PIN_W-2];
    assign recovClkSync_w = pinSync_w[PIN_W-1];

    ////////////////////////////////////////////////////////////////////////
    // Strap capture

    // Straps are static; capture reads the filtered copy
    scl_straps_s captured_r;
    scl_straps_s captured_nxt;
    logic valid_r;
    logic valid_nxt;

    always_comb begin
        captured_nxt = captured_r;
        valid_nxt = valid_r;
        if (release_w) begin
            captured_nxt = strapSync_w;
            valid_nxt = 1'b1;
        end else if (!rstStable_r) begin
            valid_nxt = 1'b0;
        end
        // Otherwise the captured value holds until next release
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            captured_r <= '0;
            valid_r <= 1'b0;
        end else if (clkEn) begin
            captured_r <= captured_nxt;
            valid_r <= valid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    function automatic scl_mode_s decodeMode(input logic [3:0] code);
        scl_mode_s m;
        m.op = SCL_OP_UNSUPPORTED;
        m.advert = `SCL_ADV_NONE;
        m.wakeEventOnIndicatorPin = 1'b0;
        m.wakeEventOnIrqPin = 1'b0;
        case (code)
            `SCL_MODE_RGMII_WAKE_IND: begin
                m.op = SCL_OP_RGMII_WAKE_IND;
                m.advert = `SCL_ADV_FULL;
                m.wakeEventOnIndicatorPin = 1'b1;
            end
            `SCL_MODE_RGMII_WAKE_IRQ: begin
                m.op = SCL_OP_RGMII_WAKE_IRQ;
                m.advert = `SCL_ADV_FULL;
                m.wakeEventOnIrqPin = 1'b1;
            end
            `SCL_MODE_RGMII_NOWAKE: begin
                m.op = SCL_OP_RGMII_NOWAKE;
                m.advert = `SCL_ADV_FULL;
            end
            `SCL_MODE_RGMII_1000FD: begin
                m.op = SCL_OP_RGMII_NOWAKE;
                m.advert = `SCL_ADV_1000FD_ONLY;
            end
            `SCL_MODE_NAND_TREE: m.op = SCL_OP_NAND_TREE;
            `SCL_MODE_POWER_DOWN: m.op = SCL_OP_POWER_DOWN;
            default: m.op = SCL_OP_UNSUPPORTED;
        endcase
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration outputs and control register

    scl_mode_s modeCfg_nxt;
    logic [4:0] mgmtAddr_nxt;
    logic bcast_r;
    logic bcast_nxt;
    logic recovSel_r;
    logic recovSel_nxt;
    logic refEn_nxt;
    logic refPin_nxt;
    logic style_nxt;
    logic wbWrite_w;
    logic wbRead_w;
    logic wbCommit_w;

    assign wbWrite_w = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o
        & ~wb_err_o;
    assign wbRead_w = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o
        & ~wb_err_o;
    // Write lands at the edge where the master sees ack
    assign wbCommit_w = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    always_comb begin
        modeCfg_nxt = decodeMode(captured_r.mode);
        mgmtAddr_nxt = {`SCL_ADDR_UPPER, captured_r.mgmtAddr};
        bcast_nxt = bcast_r;
        recovSel_nxt = recovSel_r;
        if (release_w) begin
            bcast_nxt = ~strapSync_w.broadcastAddr;
            recovSel_nxt = 1'b0;
        end else if (wbCommit_w && wb_adr_i == `SCL_REG_CTRL
            && wb_sel_i[0]) begin
            bcast_nxt = wb_dat_i[`SCL_CTRL_BCAST_BIT];
            recovSel_nxt = wb_dat_i[`SCL_CTRL_RECOV_BIT];
        end
        refEn_nxt = captured_r.refclkOut & valid_r;
        refPin_nxt = 1'b0;
        if (refEn_nxt) begin
            // Sampled copy; a real design uses a glitch-free clock mux
            refPin_nxt = recovSel_r ? recovClkSync_w
                : localClkSync_w;
        end
        style_nxt = captured_r.indicatorStyle;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeCfg <= '0;
            mgmtAddr <= 5'h00;
            bcast_r <= 1'b0;
            recovSel_r <= 1'b0;
            refclkOutEnable <= 1'b0;
            refclkOutPin <= 1'b0;
            indicatorStyle <= 1'b0;
            configValid <= 1'b0;
        end else if (clkEn) begin
            modeCfg <= modeCfg_nxt;
            mgmtAddr <= mgmtAddr_nxt;
            bcast_r <= bcast_nxt;
            recovSel_r <= recovSel_nxt;
            refclkOutEnable <= refEn_nxt;
            refclkOutPin <= refPin_nxt;
            indicatorStyle <= style_nxt;
            configValid <= valid_r;
        end
    end

    assign broadcastAddrEnableBit = bcast_r;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, err on unmapped address

    logic [31:0] rdData_nxt;
    logic ack_nxt;
    logic err_nxt;
    logic mapped_w;

    always_comb begin
        mapped_w = 1'b1;
        rdData_nxt = 32'h0000_0000;
        case (wb_adr_i)
            `SCL_REG_STRAPS: rdData_nxt = {22'h0, captured_r};
            `SCL_REG_MODE: rdData_nxt = {23'h0, modeCfg};
            `SCL_REG_CTRL: rdData_nxt = {30'h0, recovSel_r, bcast_r};
            `SCL_REG_STATUS: rdData_nxt = {26'h0, refclkOutEnable,
                indicatorStyle, rstStable_r, valid_r, 2'h0};
            default: mapped_w = 1'b0;
        endcase
        if (!wbRead_w) begin
            rdData_nxt = 32'h0000_0000;
        end
        ack_nxt = (wbRead_w | wbWrite_w) & mapped_w;
        err_nxt = (wbRead_w | wbWrite_w) & ~mapped_w;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else if (clkEn) begin
            wb_dat_o <= rdData_nxt;
            wb_ack_o <= ack_nxt;
            wb_err_o <= err_nxt;
        end
    end

endmodule // strap_config_latch
`default_nettype wire

// ---- test/scl_asserts.sv ----
`default_nettype none
module scl_asserts
    import scl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic resetPinN,
    input wire scl_straps_s strapPins,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [4:0] mgmtAddr,
    input wire logic broadcastAddrEnableBit,
    input wire logic refclkOutPin,
    input wire logic refclkOutEnable,
    input wire logic indicatorStyle,
    input wire logic configValid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    addr_upper_a: assert property (mgmtAddr[4:3] == 2'h0)
        else $error("upper address bits set");
    addr_take_a: assert property ($rose(configValid) |->
        mgmtAddr[2:0] == strapPins.mgmtAddr) else $error("address wrong");
    bcast_inv_a: assert property ($rose(configValid) |->
        broadcastAddrEnableBit != strapPins.broadcastAddr)
        else $error("broadcast default wrong");
    style_take_a: assert property ($rose(configValid) |->
        indicatorStyle == strapPins.indicatorStyle) else $error("style");
    clk_off_a: assert property (!refclkOutEnable |->
        !refclkOutPin) else $error("reference clock driven while disabled");
    cfg_hold_a: assert property (configValid &&
        $past(configValid) |-> $stable(mgmtAddr) && $stable(indicatorStyle))
        else $error("changed");
    capture_lat_a: assert property ($rose(resetPinN) |->
        ##[3:6] configValid) else $error("no capture after release");
    drop_lat_a: assert property ($fell(resetPinN) |->
        ##[1:6] !configValid) else $error("valid kept under reset");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_map_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        !wb_err_o && wb_adr_i > 8'h0c |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
endmodule // scl_asserts
bind strap_config_latch scl_asserts chk (.*);
`default_nettype wire

// ---- test/scl_board.sv ----
`default_nettype none
module scl_board
    import scl_pkg::*;
(
    input wire logic clk,
    output logic resetPinN,
    output scl_straps_s strapPins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        resetPinN = 1'b0;
        strapPins = '0;
    end
    // Straps settle while reset is held, well before release
    task automatic boot(input scl_straps_s v);
        @(posedge clk);
        resetPinN <= 1'b0;
        strapPins <= v;
        repeat (8) @(posedge clk);
        resetPinN <= 1'b1;
    endtask
    // Levels moved after capture; the device must ignore it
    task automatic wiggle(input scl_straps_s v);
        @(posedge clk);
        strapPins <= v;
    endtask
endmodule // scl_board
`default_nettype wire

// ---- test/strap_config_latch_test.sv ----
`default_nettype none
`include "scl_regs.svh"
module strap_config_latch_test
    import scl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst = 1'b1, clkEn = 1'b1, resetPinN;
    logic localRefClk = 1'b0, recoveredRxClk = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0, dr, q, seed = 32'h23;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, err, e;
    logic bcast, refPin, refEn, style, cfgOk;
    logic [4:0] mgmtAddr;
    scl_straps_s strapPins, s;
    scl_mode_s modeCfg, em;
    int error_cnt = 0, n_checks = 0;
    strap_config_latch uut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .resetPinN(resetPinN), .strapPins(strapPins),
        .localRefClk(localRefClk), .recoveredRxClk(recoveredRxClk),
        .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(4'hf), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dr), .wb_ack_o(ack),
        .wb_err_o(err), .modeCfg(modeCfg), .mgmtAddr(mgmtAddr),
        .broadcastAddrEnableBit(bcast), .refclkOutPin(refPin),
        .refclkOutEnable(refEn), .indicatorStyle(style),
        .configValid(cfgOk));
    scl_board board (.clk(clk), .resetPinN(resetPinN),
        .strapPins(strapPins));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function automatic scl_mode_s model(input logic [3:0] m);
        model = '{SCL_OP_UNSUPPORTED, 4'h0, 1'b0, 1'b0};
        case (m)
            4'h8: model = '{SCL_OP_RGMII_WAKE_IND, 4'hb, 1'b1, 1'b0};
            4'ha: model = '{SCL_OP_RGMII_WAKE_IRQ, 4'hb, 1'b0, 1'b1};
            4'he: model = '{SCL_OP_RGMII_NOWAKE, 4'hb, 1'b0, 1'b0};
            4'hc: model = '{SCL_OP_RGMII_NOWAKE, 4'h8, 1'b0, 1'b0};
            4'h4: model.op = SCL_OP_NAND_TREE;
            4'h7: model.op = SCL_OP_POWER_DOWN;
            default: ;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        // Only ack, err or the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = dr;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic boot(input scl_straps_s v);
        int n;
        board.boot(v);
        n = 0;
        while (cfgOk !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        em = model(v.mode);
        chk(modeCfg.op, em.op);
        chk(modeCfg, em);
        chk(mgmtAddr, {2'b00, v.mgmtAddr});
        chk(bcast, !v.broadcastAddr);
        chk(refEn, v.refclkOut);
        chk(style, v.indicatorStyle);
        wb(1'b0, `SCL_REG_STRAPS, 32'h0);
        chk(q, {22'h0, v});
        board.wiggle(~v);
        repeat (8) @(posedge clk);
        chk(style, v.indicatorStyle);
        chk(mgmtAddr, {2'b00, v.mgmtAddr});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            s = {i[3:0], seed[5:0]};
            boot(s);
            $display("test mode %h done", i[3:0]);
        end
        boot('{4'h8, 3'h5, 1'b1, 1'b1, 1'b0});
        wb(1'b1, `SCL_REG_CTRL, 32'h3);
        @(posedge clk);
        chk(bcast, 1'b1);
        repeat (3) @(posedge clk);
        chk(refPin, 1'b1);
        wb(1'b0, `SCL_REG_CTRL, 32'h0);
        chk(q, 32'h3);
        wb(1'b1, `SCL_REG_CTRL, 32'h0);
        // Swap source levels so only the local clock reads high
        localRefClk <= 1'b1;
        recoveredRxClk <= 1'b0;
        repeat (8) @(posedge clk);
        chk(refPin, 1'b1);
        wb(1'b0, 8'h10, 32'h0);
        chk(e, 1'b1);
        $display("test control done");
        summarize();
    end
endmodule // strap_config_latch_test
`default_nettype wire
